// File: sim/scf_front_asserts.sv
// port-level property checker for the serial command front end
`timescale 1ns/1ps
module scf_front_asserts #(
  parameter int BIT_1200 = 16,
  parameter int BIT_9600 = 16
) (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [3:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_rdata_q, // read data
  input wire logic rx, // line from host
  input wire logic tx_q, // line to host
  input wire logic cmd_valid_q, // command byte valid
  input wire logic [7:0] cmd_data_q, // command byte
  input wire logic cmd_end_q, // command end
  input wire logic bcast_q, // broadcast frame
  input wire logic reply_valid, // reply valid
  input wire logic [7:0] reply_data, // reply byte
  input wire logic reply_ready_q, // reply ready
  input wire logic res_valid, // result valid
  input wire logic [7:0] res_data, // result byte
  input wire logic res_ready_q, // result ready
  input wire logic keypad_lock_q // keypad locked
);
  logic mb_q;
  logic echo_q;
  logic auto_q;
  // shadow of the mode bits, so properties can tell scpi from modbus
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mb_q <= 1'b0;
      echo_q <= 1'b0;
      auto_q <= 1'b0;
    end else if (reg_wr && reg_addr == 4'h0) begin
      mb_q <= reg_wdata[4];
      echo_q <= reg_wdata[5];
      auto_q <= reg_wdata[6];
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  a_unmapped_reads_zero: assert property (
    reg_rd && reg_addr != 4'h0 && reg_addr != 4'h4 |=> reg_rdata_q == 16'h0000) else $error("unmapped read not zero");
  a_station_read_back: assert property (
    reg_wr && reg_addr == 4'h0 ##1 reg_rd && reg_addr == 4'h0 |=> reg_rdata_q[3:0] == $past(reg_wdata[3:0], 2))
    else $error("station number not held");
  a_scpi_end_lf: assert property (
    cmd_end_q && !mb_q |-> cmd_valid_q && cmd_data_q == 8'h0a) else $error("scpi command end without line feed");
  a_bcast_reply_drop: assert property (
    mb_q && bcast_q && reply_valid |-> ##[0:2] reply_ready_q) else $error("broadcast reply not discarded");
  a_result_drop: assert property (
    res_valid && (mb_q || !auto_q) |-> ##[0:2] res_ready_q) else $error("result not discarded");
  a_echo_before_reply: assert property (
    cmd_valid_q && echo_q && !mb_q && cmd_data_q != 8'h0a |-> ##2 !reply_ready_q) else $error("reply taken before echo");
  a_lock_on_rx: assert property (
    $fell(rx) |-> ##[1:4] keypad_lock_q) else $error("keypad not locked by serial activity");
  a_start_bit_len: assert property (
    $fell(tx_q) |-> !tx_q [*8]) else $error("start bit too short");
endmodule
bind scf_front scf_front_asserts #(.BIT_1200(BIT_1200), .BIT_9600(BIT_9600)) i_chk (
  .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .rx(rx), .tx_q(tx_q), .cmd_valid_q(cmd_valid_q), .cmd_data_q(cmd_data_q),
  .cmd_end_q(cmd_end_q), .bcast_q(bcast_q), .reply_valid(reply_valid), .reply_data(reply_data),
  .reply_ready_q(reply_ready_q), .res_valid(res_valid), .res_data(res_data), .res_ready_q(res_ready_q),
  .keypad_lock_q(keypad_lock_q));

// File: sim/scf_host.sv
// host-side serial partner: drives the device rx line, collects bytes from its tx line
`timescale 1ns/1ps
module scf_host (
  input wire logic clock, // system clock
  input wire logic tx_q, // device transmit line
  output logic rx // device receive line
);
  int bit_len = 16;
  logic [7:0] got[$];
  initial rx = 1'b1;
  // 8n1, lsb first; the line rests at the idle mark between frames
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx <= f[i];
      repeat (bit_len) @(posedge clock);
    end
  endtask
  // each line names its station first and ends with a line feed
  task automatic send_line(input int stn, input logic [7:0] body);
    string s;
    s = $sformatf("addr %02d;", stn);
    for (int i = 0; i < s.len(); i++) send_byte(s[i]);
    send_byte(body);
    send_byte(8'h0a);
  endtask
  // silence longer than 35 bit times closes a modbus frame
  task automatic gap();
    repeat (40 * bit_len) @(posedge clock);
  endtask
  always begin
    logic [7:0] b;
    @(negedge tx_q);
    repeat (bit_len / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_len) @(posedge clock);
      b[i] = tx_q;
    end
    repeat (bit_len) @(posedge clock);
    got.push_back(b);
  end
endmodule

// File: sim/test_scf_front.sv
// self-checking bench for the serial command front end
`timescale 1ns/1ps
module test_scf_front;
  typedef struct {logic [15:0] ctrl; int stn; int ncmd; int necho; int blen;} scf_row_type;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reply_valid = 1'b0;
  logic [7:0] reply_data = 8'h00;
  logic res_valid = 1'b0;
  logic [7:0] res_data = 8'h00;
  logic [15:0] reg_rdata_q;
  logic [7:0] cmd_data_q;
  logic rx, tx_q, cmd_valid_q, cmd_end_q, bcast_q, reply_ready_q, res_ready_q, keypad_lock_q;
  logic [15:0] rd;
  int failures = 0;
  int checks = 0;
  int ncmd = 0;
  int nend = 0;
  logic [7:0] first_cmd;
  // short bit times keep the run brief; 1200 differs so a wrong rate select shows
  scf_row_type rows[7] = '{'{16'h0083, 3, 2, 0, 16}, '{16'h0083, 5, 0, 0, 16}, '{16'h00a3, 3, 2, 2, 16},
    '{16'h008f, 15, 2, 0, 16}, '{16'h0080, 0, 2, 0, 16}, '{16'h0003, 3, 2, 0, 24}, '{16'h0383, 3, 2, 0, 16}};
  logic [7:0] mb[3] = '{8'h00, 8'h03, 8'h07};
  logic [15:0] rs[3] = '{16'h0083, 16'h00d3, 16'h00c3};
  logic [7:0] eo[4] = '{8'h78, 8'h0a, 8'h72, 8'h0a};
  always #12.5 clock = ~clock;
  scf_front #(.BIT_1200(24), .BIT_9600(16)) i_dut (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .rx(rx), .tx_q(tx_q), .cmd_valid_q(cmd_valid_q), .cmd_data_q(cmd_data_q),
    .cmd_end_q(cmd_end_q), .bcast_q(bcast_q), .reply_valid(reply_valid), .reply_data(reply_data),
    .reply_ready_q(reply_ready_q), .res_valid(res_valid), .res_data(res_data), .res_ready_q(res_ready_q),
    .keypad_lock_q(keypad_lock_q));
  scf_host i_host (.clock(clock), .tx_q(tx_q), .rx(rx));
  always @(posedge clock) begin
    if (cmd_valid_q === 1'b1 && ncmd == 0) first_cmd = cmd_data_q;
    if (cmd_valid_q === 1'b1) ncmd++;
    if (cmd_end_q === 1'b1) nend++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bus tasks are entered just after a rising edge, so strobes can run back to back
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    rd = reg_rdata_q;
  endtask
  task automatic push(input bit r, input logic [7:0] b);
    int n;
    n = 0;
    if (r) reply_valid <= 1'b1;
    else res_valid <= 1'b1;
    if (r) reply_data <= b;
    else res_data <= b;
    do begin
      @(posedge clock);
      n++;
    end while ((r ? reply_ready_q : res_ready_q) !== 1'b1 && n < 4000);
    chk(r ? reply_ready_q : res_ready_q, 1'b1);
    if (r) reply_valid <= 1'b0;
    else res_valid <= 1'b0;
    @(posedge clock);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rdr(4'h0);
    chk(rd, 16'h0081);
    rdr(4'h8);
    chk(rd, 16'h0000);
    foreach (rows[i]) begin
      i_host.bit_len = rows[i].blen;
      wr(4'h0, rows[i].ctrl);
      rdr(4'h0);
      chk(rd, rows[i].ctrl);
      ncmd = 0;
      nend = 0;
      i_host.got.delete();
      i_host.send_line(rows[i].stn, 8'h78);
      idle(30 * rows[i].blen);
      chk(ncmd, rows[i].ncmd);
      chk(nend, rows[i].ncmd / 2);
      if (rows[i].ncmd > 0) chk(first_cmd, 8'h78);
      chk(i_host.got.size(), rows[i].necho);
      if (rows[i].necho > 0) chk(i_host.got[0], 8'h78);
    end
    i_host.bit_len = 16;
    wr(4'h0, 16'h00b3);
    foreach (mb[i]) begin
      ncmd = 0;
      nend = 0;
      i_host.got.delete();
      i_host.send_byte(mb[i]);
      i_host.send_byte(8'h06);
      i_host.gap();
      chk(ncmd, mb[i] == 8'h07 ? 0 : 2);
      chk(nend, mb[i] == 8'h07 ? 0 : 1);
      if (mb[i] != 8'h07) chk(first_cmd, mb[i]);
      chk(bcast_q, mb[i] == 8'h00);
      if (mb[i] == 8'h00) push(1'b1, 8'h0a);
      idle(400);
      chk(i_host.got.size(), 0);
      rdr(4'h4);
      chk(rd[5:1], {4'h0, mb[i] == 8'h00});
    end
    foreach (rs[i]) begin
      wr(4'h0, rs[i]);
      i_host.got.delete();
      push(1'b0, 8'h35);
      push(1'b0, 8'h0a);
      idle(400);
      chk(i_host.got.size(), rs[i] == 16'h00c3 ? 2 : 0);
    end
    chk(i_host.got[0], 8'h35);
    wr(4'h0, 16'h00a3);
    i_host.got.delete();
    fork
      i_host.send_line(3, 8'h78);
      begin
        @(posedge clock iff cmd_valid_q === 1'b1);
        push(1'b1, 8'h72);
        push(1'b1, 8'h0a);
      end
    join
    idle(800);
    chk(i_host.got.size(), 4);
    foreach (eo[i]) chk(i_host.got[i], eo[i]);
    rdr(4'h4);
    chk(rd[0], 1'b1);
    chk(keypad_lock_q, 1'b1);
    wr(4'h4, 16'h0001);
    rdr(4'h4);
    chk(rd[0], 1'b0);
    print_verdict();
  end
endmodule

// File: src/scf_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module scf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write data
  output logic out_valid, // data available
  input wire logic out_ready, // read request
  output logic [WIDTH-1:0] out_data, // head word
  output logic [$clog2(DEPTH):0] level // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign level = cnt_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: src/scf_front.sv
// serial command front end: uart, station filter, echo, result push and register port
`timescale 1ns/1ps
`include "scf_map.svh"
module scf_front #(
  parameter int BIT_1200 = `SCF_CLK_HZ / `SCF_BAUD_1200,
  parameter int BIT_9600 = `SCF_CLK_HZ / `SCF_BAUD_9600
) (
  input wire logic clock, // 40 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire logic [3:0] reg_addr, // register byte address
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata_q, // read data, cycle after reg_rd
  input wire logic rx, // serial line from host
  output logic tx_q, // serial line to host
  output logic cmd_valid_q, // accepted command byte
  output logic [7:0] cmd_data_q, // command byte
  output logic cmd_end_q, // end of accepted command or frame
  output logic bcast_q, // current modbus frame is a broadcast
  input wire logic reply_valid, // reply byte from command engine
  input wire logic [7:0] reply_data, // reply byte
  output logic reply_ready_q, // reply byte taken this cycle if valid
  input wire logic res_valid, // test result byte
  input wire logic [7:0] res_data, // result byte
  output logic res_ready_q, // result byte taken this cycle if valid
  output logic keypad_lock_q // local keypad locked
);
  localparam int DW = $clog2(`SCF_TX_DEPTH);
  localparam logic [15:0] LEN_1200 = 16'(BIT_1200);
  localparam logic [15:0] LEN_9600 = 16'(BIT_9600);
  localparam logic [15:0] LEN_38400 = 16'(`SCF_CLK_HZ / `SCF_BAUD_38400);
  localparam logic [15:0] LEN_57600 = 16'(`SCF_CLK_HZ / `SCF_BAUD_57600);
  localparam logic [15:0] LEN_115200 = 16'(`SCF_CLK_HZ / `SCF_BAUD_115200);

  logic [3:0] station_q;
  logic modbus_q;
  logic echo_en_q;
  logic auto_q;
  logic [2:0] baud_q;
  logic [15:0] bit_len;
  scf_pkg::scf_rx_type rx_st_q;
  logic [15:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_stb_q;
  logic [7:0] rx_byte_q;
  logic [15:0] tick_cnt_q;
  logic [5:0] quiet_q;
  logic in_frame_q;
  logic acc_q;
  logic frame_end;
  logic acc_now;
  scf_pkg::scf_parse_type ps_q;
  logic [1:0] tag_q;
  logic [6:0] num_q;
  logic [7:0] low_byte;
  logic is_digit;
  logic is_lf;
  logic fwd;
  logic echo_pend_q;
  logic [7:0] echo_byte_q;
  logic echo_busy_q;
  scf_pkg::scf_own_type own_q;
  logic gnt_q;
  logic push_rep;
  logic push_res;
  logic push_echo;
  logic push_valid;
  logic [7:0] push_data;
  logic drop_rep;
  logic drop_res;
  logic room;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic [DW:0] fifo_level;
  logic tx_busy_q;
  logic [8:0] tx_sh_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bits_q;

  always_comb begin
    case (baud_q)
      `SCF_SEL_1200: bit_len = LEN_1200;
      `SCF_SEL_9600: bit_len = LEN_9600;
      `SCF_SEL_38400: bit_len = LEN_38400;
      `SCF_SEL_57600: bit_len = LEN_57600;
      `SCF_SEL_115200: bit_len = LEN_115200;
      default: bit_len = LEN_9600;
    endcase
  end

  // configuration register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      station_q <= `SCF_RST_STATION;
      modbus_q <= 1'b0;
      echo_en_q <= 1'b0;
      auto_q <= 1'b0;
      baud_q <= `SCF_RST_BAUD;
    end else if (reg_wr && reg_addr == `SCF_REG_CTRL) begin
      station_q <= reg_wdata[`SCF_CTRL_STN_MSB:`SCF_CTRL_STN_LSB];
      modbus_q <= reg_wdata[`SCF_CTRL_MODBUS];
      echo_en_q <= reg_wdata[`SCF_CTRL_ECHO];
      auto_q <= reg_wdata[`SCF_CTRL_AUTO];
      baud_q <= reg_wdata[`SCF_CTRL_BAUD_MSB:`SCF_CTRL_BAUD_LSB];
    end
  end

  // activity on the line wins over a software clear in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      keypad_lock_q <= 1'b0;
    end else if (!rx) begin
      keypad_lock_q <= 1'b1;
    end else if (reg_wr && reg_addr == `SCF_REG_STAT && reg_wdata[`SCF_STAT_LOCK]) begin
      keypad_lock_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      reg_rdata_q <= '0;
      if (reg_addr == `SCF_REG_CTRL) begin
        reg_rdata_q[`SCF_CTRL_STN_MSB:`SCF_CTRL_STN_LSB] <= station_q;
        reg_rdata_q[`SCF_CTRL_MODBUS] <= modbus_q;
        reg_rdata_q[`SCF_CTRL_ECHO] <= echo_en_q;
        reg_rdata_q[`SCF_CTRL_AUTO] <= auto_q;
        reg_rdata_q[`SCF_CTRL_BAUD_MSB:`SCF_CTRL_BAUD_LSB] <= baud_q;
      end else if (reg_addr == `SCF_REG_STAT) begin
        reg_rdata_q[`SCF_STAT_LOCK] <= keypad_lock_q;
        reg_rdata_q[`SCF_STAT_BCAST] <= bcast_q;
        reg_rdata_q[`SCF_STAT_LVL_MSB:`SCF_STAT_LVL_LSB] <= fifo_level;
      end
    end
  end

  // receiver: samples each bit at its middle; 8 data bits, no parity, 1 stop
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_st_q <= scf_pkg::SCF_RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_stb_q <= 1'b0;
      rx_byte_q <= '0;
    end else begin
      rx_stb_q <= 1'b0;
      case (rx_st_q)
        scf_pkg::SCF_RX_IDLE: begin
          if (!rx) begin
            rx_st_q <= scf_pkg::SCF_RX_START;
            rx_cnt_q <= bit_len >> 1;
          end
        end
        scf_pkg::SCF_RX_START: begin
          if (rx_cnt_q == '0) begin
            rx_st_q <= rx ? scf_pkg::SCF_RX_IDLE : scf_pkg::SCF_RX_DATA;
            rx_cnt_q <= bit_len - 16'h0001;
            rx_bit_q <= '0;
          end else begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end
        end
        scf_pkg::SCF_RX_DATA: begin
          if (rx_cnt_q == '0) begin
            rx_sh_q <= {rx, rx_sh_q[7:1]};
            rx_cnt_q <= bit_len - 16'h0001;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7) begin
              rx_st_q <= scf_pkg::SCF_RX_STOP;
            end
          end else begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end
        end
        scf_pkg::SCF_RX_STOP: begin
          if (rx_cnt_q == '0) begin
            rx_st_q <= scf_pkg::SCF_RX_IDLE;
            rx_stb_q <= rx; // a low stop bit drops the byte
            rx_byte_q <= rx_sh_q;
          end else begin
            rx_cnt_q <= rx_cnt_q - 16'h0001;
          end
        end
        default: rx_st_q <= scf_pkg::SCF_RX_IDLE;
      endcase
    end
  end

  // bit-rate tick enable times the modbus inter-frame silence
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= '0;
      quiet_q <= '0;
    end else begin
      tick_cnt_q <= (tick_cnt_q == '0) ? bit_len - 16'h0001 : tick_cnt_q - 16'h0001;
      if (!rx || rx_st_q != scf_pkg::SCF_RX_IDLE) begin
        quiet_q <= '0;
      end else if (tick_cnt_q == '0 && quiet_q != `SCF_SILENCE_BITS) begin
        quiet_q <= quiet_q + 6'h01;
      end
    end
  end

  assign frame_end = in_frame_q && quiet_q == `SCF_SILENCE_BITS;
  assign acc_now = rx_byte_q == {4'h0, station_q} || rx_byte_q == `SCF_BCAST_ADDR;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      in_frame_q <= 1'b0;
      acc_q <= 1'b0;
      bcast_q <= 1'b0;
    end else if (modbus_q && rx_stb_q && !in_frame_q) begin
      in_frame_q <= 1'b1;
      acc_q <= acc_now;
      bcast_q <= rx_byte_q == `SCF_BCAST_ADDR;
    end else if (frame_end || !modbus_q) begin
      in_frame_q <= 1'b0;
      if (!modbus_q) begin
        bcast_q <= 1'b0;
      end
    end
  end

  // scpi line parser: "addr NN;" must lead every line
  assign low_byte = rx_byte_q | `SCF_CASE_BIT;
  assign is_digit = rx_byte_q >= `SCF_CH_0 && rx_byte_q <= `SCF_CH_9;
  assign is_lf = rx_byte_q == `SCF_CH_LF;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ps_q <= scf_pkg::SCF_PS_HEAD;
      tag_q <= '0;
      num_q <= '0;
    end else if (modbus_q) begin
      ps_q <= scf_pkg::SCF_PS_HEAD;
    end else if (rx_stb_q) begin
      if (is_lf) begin
        ps_q <= scf_pkg::SCF_PS_HEAD;
      end else begin
        case (ps_q)
          scf_pkg::SCF_PS_HEAD: begin
            ps_q <= (low_byte == `SCF_CH_A) ? scf_pkg::SCF_PS_TAG : scf_pkg::SCF_PS_SKIP;
            tag_q <= '0;
          end
          scf_pkg::SCF_PS_TAG: begin
            tag_q <= tag_q + 2'h1;
            if (low_byte != ((tag_q == 2'h2) ? `SCF_CH_R : `SCF_CH_D)) begin
              ps_q <= scf_pkg::SCF_PS_SKIP;
            end else if (tag_q == 2'h2) begin
              ps_q <= scf_pkg::SCF_PS_SPACE;
            end
          end
          scf_pkg::SCF_PS_SPACE: begin
            num_q <= 7'(rx_byte_q - `SCF_CH_0);
            if (is_digit) begin
              ps_q <= scf_pkg::SCF_PS_NUM;
            end else if (rx_byte_q != `SCF_CH_SP) begin
              ps_q <= scf_pkg::SCF_PS_SKIP;
            end
          end
          scf_pkg::SCF_PS_NUM: begin
            if (is_digit && num_q < 7'h0a) begin
              num_q <= 7'(num_q * 7'h0a + 7'(rx_byte_q - `SCF_CH_0));
            end else if (rx_byte_q == `SCF_CH_SEMI && num_q == {3'h0, station_q}) begin
              ps_q <= scf_pkg::SCF_PS_PASS;
            end else begin
              ps_q <= scf_pkg::SCF_PS_SKIP;
            end
          end
          scf_pkg::SCF_PS_PASS: ps_q <= scf_pkg::SCF_PS_PASS;
          scf_pkg::SCF_PS_SKIP: ps_q <= scf_pkg::SCF_PS_SKIP;
          default: ps_q <= scf_pkg::SCF_PS_SKIP;
        endcase
      end
    end
  end

  always_comb begin
    if (modbus_q) begin
      fwd = rx_stb_q && (in_frame_q ? acc_q : acc_now);
    end else begin
      fwd = rx_stb_q && ps_q == scf_pkg::SCF_PS_PASS;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmd_valid_q <= 1'b0;
      cmd_data_q <= '0;
      cmd_end_q <= 1'b0;
    end else begin
      cmd_valid_q <= fwd;
      cmd_data_q <= rx_byte_q;
      cmd_end_q <= modbus_q ? (frame_end && acc_q) : (fwd && is_lf);
    end
  end

  // echo holds replies back until the command's line feed is queued
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      echo_pend_q <= 1'b0;
      echo_byte_q <= '0;
      echo_busy_q <= 1'b0;
    end else begin
      if (fwd && echo_en_q && !modbus_q) begin
        echo_pend_q <= 1'b1;
        echo_byte_q <= rx_byte_q;
        echo_busy_q <= 1'b1;
      end else if (push_echo) begin
        echo_pend_q <= 1'b0;
        if (echo_byte_q == `SCF_CH_LF) begin
          echo_busy_q <= 1'b0;
        end
      end
      if (modbus_q) begin
        echo_pend_q <= 1'b0;
        echo_busy_q <= 1'b0;
      end
    end
  end

  // transmit side: replies, pushed results and echo share one fifo; replies and results go one line at a time, echo bytes fill free cycles
  assign drop_rep = modbus_q && bcast_q;
  assign drop_res = modbus_q || !auto_q;
  assign push_rep = reply_valid && reply_ready_q && !drop_rep;
  assign push_res = res_valid && res_ready_q && !drop_res;
  assign push_echo = echo_pend_q && !push_rep && !push_res && fifo_in_ready;
  assign push_valid = push_rep || push_res || push_echo;
  assign push_data = push_rep ? reply_data : (push_res ? res_data : echo_byte_q);
  // ready is registered, so keep enough slack for the cycle it lags by
  assign room = fifo_level < `SCF_TX_MARGIN;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      own_q <= scf_pkg::SCF_OWN_IDLE;
      gnt_q <= 1'b0;
      reply_ready_q <= 1'b0;
      res_ready_q <= 1'b0;
    end else begin
      gnt_q <= !gnt_q;
      if (push_rep) begin
        own_q <= (reply_data == `SCF_CH_LF) ? scf_pkg::SCF_OWN_IDLE : scf_pkg::SCF_OWN_REPLY;
      end else if (push_res) begin
        own_q <= (res_data == `SCF_CH_LF) ? scf_pkg::SCF_OWN_IDLE : scf_pkg::SCF_OWN_RESULT;
      end
      reply_ready_q <= drop_rep || (room && !echo_busy_q && (own_q == scf_pkg::SCF_OWN_REPLY ||
                       (own_q == scf_pkg::SCF_OWN_IDLE && !gnt_q && !push_res)));
      res_ready_q <= drop_res || (room && (own_q == scf_pkg::SCF_OWN_RESULT ||
                     (own_q == scf_pkg::SCF_OWN_IDLE && gnt_q && !push_rep)));
    end
  end

  scf_fifo #(
    .WIDTH(8),
    .DEPTH(`SCF_TX_DEPTH)
  ) u_tx_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(!tx_busy_q),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // transmitter: start bit, 8 data bits lsb first, stop bit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_q <= 1'b1;
      tx_busy_q <= 1'b0;
      tx_sh_q <= '1;
      tx_cnt_q <= '0;
      tx_bits_q <= '0;
    end else if (!tx_busy_q) begin
      if (fifo_out_valid) begin
        tx_q <= 1'b0;
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, fifo_out_data};
        tx_cnt_q <= bit_len - 16'h0001;
        tx_bits_q <= `SCF_FRAME_BITS;
      end
    end else if (tx_cnt_q != '0) begin
      tx_cnt_q <= tx_cnt_q - 16'h0001;
    end else if (tx_bits_q == '0) begin
      tx_busy_q <= 1'b0;
    end else begin
      tx_q <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[8:1]};
      tx_bits_q <= tx_bits_q - 4'h1;
      tx_cnt_q <= bit_len - 16'h0001;
    end
  end
endmodule

// File: src/scf_map.svh
// constants, register map and character codes of the serial command front end
//
// Contract
// - station number 00..15 held in a register, used as own Modbus address
// - SCPI lines must start with an addr prefix naming this station to be accepted
// - Modbus frames to station 00 are executed by all, never answered
// - echo on: each accepted command is sent back before any reply data
// - echo off: commands pass straight through, nothing echoed
// - echo setting honoured only under SCPI, ignored under Modbus
// - auto mode: each finished test result is sent without a query
// - query mode: results leave only as replies to the host's query
// - auto/query result selection honoured only under SCPI
// - one selectable bit rate: 1200, 9600, 38400, 57600 or 115200 baud
// - serial activity locks the local keypad
`ifndef SCF_MAP_SVH
`define SCF_MAP_SVH

`define SCF_CLK_HZ 40000000
`define SCF_BAUD_1200 1200
`define SCF_BAUD_9600 9600
`define SCF_BAUD_38400 38400
`define SCF_BAUD_57600 57600
`define SCF_BAUD_115200 115200
`define SCF_SEL_1200 3'h0
`define SCF_SEL_9600 3'h1
`define SCF_SEL_38400 3'h2
`define SCF_SEL_57600 3'h3
`define SCF_SEL_115200 3'h4

`define SCF_REG_CTRL 4'h0
`define SCF_REG_STAT 4'h4
`define SCF_CTRL_STN_LSB 0
`define SCF_CTRL_STN_MSB 3
`define SCF_CTRL_MODBUS 4
`define SCF_CTRL_ECHO 5
`define SCF_CTRL_AUTO 6
`define SCF_CTRL_BAUD_LSB 7
`define SCF_CTRL_BAUD_MSB 9
`define SCF_STAT_LOCK 0
`define SCF_STAT_BCAST 1
`define SCF_STAT_LVL_LSB 2
`define SCF_STAT_LVL_MSB 5

`define SCF_RST_STATION 4'h1
`define SCF_RST_BAUD 3'h1
`define SCF_BCAST_ADDR 8'h00

`define SCF_SILENCE_BITS 6'h23
`define SCF_TX_DEPTH 8
`define SCF_TX_MARGIN 4'h5
`define SCF_FRAME_BITS 4'h9

`define SCF_CH_LF 8'h0a
`define SCF_CH_SP 8'h20
`define SCF_CH_SEMI 8'h3b
`define SCF_CH_0 8'h30
`define SCF_CH_9 8'h39
`define SCF_CH_A 8'h61
`define SCF_CH_D 8'h64
`define SCF_CH_R 8'h72
`define SCF_CASE_BIT 8'h20

`endif

// File: src/scf_pkg.sv
// state types of the serial command front end
package scf_pkg;

  typedef enum logic [1:0] {
    SCF_RX_IDLE = 2'b00,
    SCF_RX_START = 2'b01,
    SCF_RX_DATA = 2'b10,
    SCF_RX_STOP = 2'b11
  } scf_rx_type;

  typedef enum logic [2:0] {
    SCF_PS_HEAD = 3'b000,
    SCF_PS_TAG = 3'b001,
    SCF_PS_SPACE = 3'b010,
    SCF_PS_NUM = 3'b011,
    SCF_PS_PASS = 3'b100,
    SCF_PS_SKIP = 3'b101
  } scf_parse_type;

  typedef enum logic [1:0] {
    SCF_OWN_IDLE = 2'b00,
    SCF_OWN_REPLY = 2'b01,
    SCF_OWN_RESULT = 2'b10
  } scf_own_type;

endpackage
